// File: hwdt_pkg.sv
// Shared constants for the hardware watchdog timer block
package hwdt_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices (byte address is four times the index)
	localparam logic [7:0]  SVC_KEY_IDX   = 8'ha6;
	localparam logic [7:0]  TSEL_IDX      = 8'ha7;
	localparam int          ADDR_W        = 12;

	////////////////////////////////////////////////////////////////////////////////
	// Key bytes for enable and service
	localparam logic [7:0]  KEY_FIRST     = 8'h1e;
	localparam logic [7:0]  KEY_SECOND    = 8'he1;

	////////////////////////////////////////////////////////////////////////////////
	// Timeout select field
	localparam int          TSEL_W        = 3;
	localparam int          TSEL_LSB      = 0;
	localparam logic [2:0]  TSEL_RST      = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Counter widths
	localparam int          BASE_BITS     = 14;
	localparam int          PRESC_BITS    = 7;
	localparam int          CNT_W         = BASE_BITS + PRESC_BITS;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: pclk is the peripheral clock, 10 ns period
	localparam int          PCLK_NS       = 10;
	localparam logic [3:0]  MC_CLKS       = 4'hc;
	localparam int          PULSE_PERIODS = 96;
	localparam int          PULSE_NS      = PULSE_PERIODS * PCLK_NS;
	localparam logic [6:0]  PULSE_CLKS    = 7'(PULSE_NS / PCLK_NS);

	////////////////////////////////////////////////////////////////////////////////
	// Key sequence states
	typedef enum logic {
		KEY_IDLE  = 1'b0,
		KEY_ARMED = 1'b1
	} hwdt_key_t;

endpackage

// File: hwdt_pulse.sv
// Fixed-length reset pulse generator
`timescale 1ns/1ns
module hwdt_pulse (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Trigger and pulse
	input  wire logic start,
	output logic      pulse_q
);

	logic [6:0] left_q;
	logic [6:0] left_d;
	logic       pulse_d;

	////////////////////////////////////////////////////////////////////////////////
	// Next state: load on start, count down while high
	assign pulse_d = start | (pulse_q & (left_q != 7'h00));
	assign left_d  = start ? 7'(hwdt_pkg::PULSE_CLKS - 7'h01) :
	                 (pulse_q && left_q != 7'h00) ? 7'(left_q - 7'h01) : 7'h00; // R7

	// Pulse registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_q <= 1'b0;
			left_q  <= 7'h00;
		end else begin
			pulse_q <= pulse_d;
			left_q  <= left_d;
		end
	end

endmodule // hwdt_pulse

// File: hwdt_top.sv
// Hardware watchdog timer with APB register access and reset-out pulse
//
// Functional notes
// [R1] Watchdog starts disabled after every reset
// [R2] Key pair 1E then E1 enables watchdog
// [R3] Enabled counter advances once per machine cycle
// [R4] Only reset or overflow disables it
// [R5] Key pair while enabled restarts count
// [R6] Counter overflow at all-ones resets device
// [R7] Reset pulse lasts 96 peripheral clocks
// [R8] Service register write-only, counter hidden
// [R9] Software services before the selected timeout
// [R10] Three-bit select extends timeout via prescaler
// [R11] Select field resets to zero, upper zero
// [R12] Counting held while wake interrupt low after power-down exit by interrupt
// [R13] Wrong write after first key discards
`timescale 1ns/1ns
module hwdt_top #(
	parameter int BASE_BITS = hwdt_pkg::BASE_BITS
) (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB request
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	// APB answer
	output logic [31:0]      prdata_q,
	output logic             pready_q,
	output logic             pslverr_q,
	// Power and wake status
	input  wire logic        osc_running,
	input  wire logic        pd_exit_by_int,
	input  wire logic        wake_int_n,
	// Reset pin drive
	output logic             rst_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Timeout mask: low BASE_BITS+sel bits set
	function automatic logic [hwdt_pkg::CNT_W-1:0] limit_mask(input logic [2:0] sel);
		logic [hwdt_pkg::CNT_W:0] one_hot;
		one_hot    = '0;
		one_hot    = (hwdt_pkg::CNT_W+1)'(1) << (BASE_BITS + int'(sel));
		limit_mask = (hwdt_pkg::CNT_W)'(one_hot - (hwdt_pkg::CNT_W+1)'(1));
	endfunction

	// Address compare against a register index
	function automatic logic addr_is(input logic [11:0] addr, input logic [7:0] idx);
		addr_is = (addr == {2'b00, idx, 2'b00});
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic                          en_q;
	logic                          en_d;
	logic [hwdt_pkg::CNT_W-1:0]    cnt_q;
	logic [hwdt_pkg::CNT_W-1:0]    cnt_d;
	logic [3:0]                    mc_q;
	logic [3:0]                    mc_d;
	logic [2:0]                    tsel_q;
	logic [2:0]                    tsel_d;
	hwdt_pkg::hwdt_key_t           key_q;
	hwdt_pkg::hwdt_key_t           key_d;
	logic [31:0]                   prdata_d;
	logic                          pready_d;
	logic                          pslverr_d;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	wire setup     = psel & ~penable;
	wire hit_svc   = addr_is(paddr, hwdt_pkg::SVC_KEY_IDX);
	wire hit_tsel  = addr_is(paddr, hwdt_pkg::TSEL_IDX);
	wire mapped    = hit_svc | hit_tsel;
	wire take      = psel & penable & pready_q;
	wire wr_take   = take & pwrite & mapped;
	wire wr_svc    = wr_take & hit_svc;
	wire wr_tsel   = wr_take & hit_tsel;
	wire [7:0] wbyte = pwdata[7:0];

	// Answer prepared in setup, shown in the single access cycle
	assign pready_d  = setup;
	assign pslverr_d = setup & ~mapped;
	assign prdata_d  = (setup && !pwrite && hit_tsel) ? {29'h0, tsel_q} : 32'h0; // R8 R11

	////////////////////////////////////////////////////////////////////////////////
	// Key sequence tracking
	wire key1_wr = wr_svc & (wbyte == hwdt_pkg::KEY_FIRST);
	wire key2_wr = wr_svc & (wbyte == hwdt_pkg::KEY_SECOND);
	wire svc_ok  = key2_wr & (key_q == hwdt_pkg::KEY_ARMED); // R2 R5

	always_comb begin
		key_d = key_q;
		case (key_q)
			hwdt_pkg::KEY_IDLE: begin
				if (key1_wr)
					key_d = hwdt_pkg::KEY_ARMED;
			end
			hwdt_pkg::KEY_ARMED: begin
				if (key1_wr)
					key_d = hwdt_pkg::KEY_ARMED;
				else if (wr_take)
					key_d = hwdt_pkg::KEY_IDLE; // R13
			end
			default: key_d = hwdt_pkg::KEY_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter control
	wire                       mc_tick = osc_running & (mc_q == 4'(hwdt_pkg::MC_CLKS - 4'h1)); // R3
	wire                       hold    = pd_exit_by_int & ~wake_int_n; // R12
	wire [hwdt_pkg::CNT_W-1:0] mask    = limit_mask(tsel_q); // R10
	wire                       ovf     = en_q & (cnt_q >= mask); // R6

	assign mc_d   = !osc_running ? mc_q : mc_tick ? 4'h0 : 4'(mc_q + 4'h1);
	assign en_d   = ovf ? 1'b0 : (en_q | svc_ok); // R1 R2 R4
	assign cnt_d  = (svc_ok || ovf || !en_q) ? '0 : // R5
	                (mc_tick && !hold) ? (hwdt_pkg::CNT_W)'(cnt_q + 1'b1) : cnt_q; // R3 R12
	assign tsel_d = wr_tsel ? wbyte[hwdt_pkg::TSEL_LSB +: hwdt_pkg::TSEL_W] : tsel_q; // R10

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q   <= 1'b0; // R1
			cnt_q  <= '0;
			mc_q   <= 4'h0;
			tsel_q <= hwdt_pkg::TSEL_RST; // R11
			key_q  <= hwdt_pkg::KEY_IDLE;
		end else begin
			en_q   <= en_d;
			cnt_q  <= cnt_d;
			mc_q   <= mc_d;
			tsel_q <= tsel_d;
			key_q  <= key_d;
		end
	end

	// APB answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset-out pulse
	hwdt_pulse u_pulse (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (ovf), // R6
		.pulse_q (rst_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Helper: length of current reset pulse
	logic [7:0] hi_len_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_len_q <= 8'h00;
		else
			hi_len_q <= rst_out ? 8'(hi_len_q + 8'h01) : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions: bus answer, register field, key sequence, counter and reset pulse internals
	// Answer follows every setup
	a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready_q)
		else $error("no ready after setup");

	// Ready stands one cycle only
	a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		pready_q |=> !pready_q)
		else $error("ready held too long");

	// Ready never without a setup before it
	a_ready_from_setup: assert property (@(posedge pclk) disable iff (!presetn)
		pready_q |-> $past(setup))
		else $error("ready without setup");

	// Unmapped address gives an error answer
	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !mapped |=> pslverr_q)
		else $error("unmapped access without error");

	// Mapped address gives a clean answer
	a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		setup && mapped |=> !pslverr_q)
		else $error("mapped access with error");

	// Read bus shows nothing outside an answer
	a_read_idle_zero: assert property (@(posedge pclk) disable iff (!presetn) // R8
		!pready_q |-> prdata_q == 32'h0)
		else $error("read data outside answer");

	// Select write lands in the field
	a_tsel_write: assert property (@(posedge pclk) disable iff (!presetn) // R10
		wr_tsel |=> tsel_q == $past(wbyte[hwdt_pkg::TSEL_LSB +: hwdt_pkg::TSEL_W]))
		else $error("timeout select write lost");

	// Select field moves only on its write
	a_tsel_keep: assert property (@(posedge pclk) disable iff (!presetn) // R10
		!wr_tsel |=> $stable(tsel_q))
		else $error("timeout select changed without write");

	// First key byte arms the sequence
	a_key_arms: assert property (@(posedge pclk) disable iff (!presetn) // R2
		key1_wr |=> key_q == hwdt_pkg::KEY_ARMED)
		else $error("first key byte not taken");

	// Disabled watchdog keeps its count at zero
	a_off_count_zero: assert property (@(posedge pclk) disable iff (!presetn) // R1
		!en_q |-> cnt_q == '0)
		else $error("count moved while disabled");

	// Overflow clears the count
	a_ovf_clears: assert property (@(posedge pclk) disable iff (!presetn) // R6
		ovf |=> cnt_q == '0)
		else $error("count not cleared on overflow");

	// Stopped oscillator freezes the count
	a_osc_stop: assert property (@(posedge pclk) disable iff (!presetn) // R3
		en_q && !osc_running && !svc_ok && !ovf |=> $stable(cnt_q))
		else $error("count moved with oscillator stopped");

	// Stopped oscillator freezes the machine cycle divider
	a_mc_frozen: assert property (@(posedge pclk) disable iff (!presetn) // R3
		!osc_running |=> $stable(mc_q))
		else $error("machine cycle moved with oscillator stopped");

	// Divider stays inside one machine cycle
	a_mc_range: assert property (@(posedge pclk) disable iff (!presetn) // R3
		mc_q < hwdt_pkg::MC_CLKS)
		else $error("machine cycle divider out of range");

	// Pulse never outlasts its length
	a_pulse_in_len: assert property (@(posedge pclk) disable iff (!presetn) // R7
		rst_out |-> hi_len_q < 8'(hwdt_pkg::PULSE_PERIODS))
		else $error("reset pulse too long");

	// Pulse starts only from an overflow
	a_pulse_needs_ovf: assert property (@(posedge pclk) disable iff (!presetn) // R6
		!ovf && !rst_out |=> !rst_out)
		else $error("reset pulse without overflow");

	////////////////////////////////////////////////////////////////////////////////
	// Assertions: watchdog rules
	a_off_stays_off: assert property (@(posedge pclk) disable iff (!presetn) // R1
		!en_q && !svc_ok |=> !en_q)
		else $error("watchdog enabled without key pair");

	a_key_enables: assert property (@(posedge pclk) disable iff (!presetn) // R2
		!en_q && svc_ok |=> en_q && cnt_q == '0)
		else $error("key pair did not enable watchdog");

	a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // R3
		en_q && mc_tick && !hold && !ovf && !svc_ok |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("counter did not advance on machine cycle");

	a_no_sw_off: assert property (@(posedge pclk) disable iff (!presetn) // R4
		en_q && !ovf |=> en_q)
		else $error("watchdog disabled without overflow");

	a_service_clear: assert property (@(posedge pclk) disable iff (!presetn) // R5
		en_q && svc_ok |=> en_q && cnt_q == '0)
		else $error("service did not restart count");

	a_ovf_reset: assert property (@(posedge pclk) disable iff (!presetn) // R6
		ovf |=> rst_out && !en_q)
		else $error("overflow gave no reset pulse");

	a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn) // R7
		$fell(rst_out) |-> hi_len_q == 8'(hwdt_pkg::PULSE_PERIODS))
		else $error("reset pulse length wrong");

	a_svc_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // R8
		psel && penable && !pwrite && hit_svc |-> prdata_q == 32'h0)
		else $error("service register read not zero");

	a_tsel_read: assert property (@(posedge pclk) disable iff (!presetn) // R11
		psel && penable && !pwrite && hit_tsel |-> prdata_q == {29'h0, tsel_q})
		else $error("timeout select readback wrong");

	a_wake_hold: assert property (@(posedge pclk) disable iff (!presetn) // R12
		en_q && hold && !svc_ok && !ovf |=> $stable(cnt_q))
		else $error("counter moved while wake pin low");

	a_seq_discard: assert property (@(posedge pclk) disable iff (!presetn) // R13
		key_q == hwdt_pkg::KEY_ARMED && wr_take && !key1_wr && !key2_wr |=> key_q == hwdt_pkg::KEY_IDLE)
		else $error("partial key sequence not discarded");

	// Cover points for the main scenarios
	c_enable:   cover property (@(posedge pclk) disable iff (!presetn) !en_q ##1 en_q);
	c_service:  cover property (@(posedge pclk) disable iff (!presetn) en_q && svc_ok);
	c_overflow: cover property (@(posedge pclk) disable iff (!presetn) ovf ##1 rst_out);
	c_pulse_end: cover property (@(posedge pclk) disable iff (!presetn) $fell(rst_out));

endmodule // hwdt_top

// File: hardware_watchdog_timer_tb.sv
// Self-checking testbench for the hardware watchdog timer
`timescale 1ns/1ns
module hardware_watchdog_timer_tb;
	localparam int          BB    = 4;
	localparam int          T0    = 2 ** BB - 1;
	localparam logic [11:0] A_KEY = 12'({hwdt_pkg::SVC_KEY_IDX, 2'b00});
	localparam logic [11:0] A_SEL = 12'({hwdt_pkg::TSEL_IDX, 2'b00});
	logic        pclk, presetn, psel, penable, pwrite, osc_running, pd_exit_by_int, wake_int_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_q, rd;
	logic        pready_q, pslverr_q, rst_out, err;
	int          n_errors, cmp_count, c;

	hwdt_top #(.BASE_BITS(BB)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .osc_running(osc_running), .pd_exit_by_int(pd_exit_by_int),
		.wake_int_n(wake_int_n), .rst_out(rst_out));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, comparison and closing
	always #5 pclk = ~pclk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// APB master, key writes and reset-pin watching
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready_q !== 1'b1);
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready_wait", 32'(k), 32'h1);
		@(posedge pclk);
	endtask
	task automatic key(input logic [7:0] b);
		apb(1'b1, A_KEY, {24'hffffff, b});
	endtask
	task automatic arm;
		key(hwdt_pkg::KEY_FIRST);
		key(hwdt_pkg::KEY_SECOND);
	endtask
	task automatic wait_rst(input int lim);
		c = 0;
		while (rst_out !== 1'b1 && c < lim) begin
			@(posedge pclk);
			c++;
		end
	endtask
	task automatic expect_ovf(input int t);
		wait_rst(t * 12 + 40);
		chk("ovf_early", 32'(c >= (t - 1) * 12), 32'h1);
		chk("ovf_late", 32'(c <= t * 12 + 3), 32'h1);
		c = 1;
		@(posedge pclk);
		while (rst_out === 1'b1 && c < 200) begin
			c++;
			@(posedge pclk);
		end
		chk("pulse_len", 32'(c), 32'(hwdt_pkg::PULSE_PERIODS));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs;
		apb(1'b0, A_SEL, 32'h0);
		chk("sel_reset", rd, 32'h0);
		apb(1'b0, A_KEY, 32'h0);
		chk("key_read", rd, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("unmapped_err", 32'(err), 32'h1);
		apb(1'b1, A_SEL, 32'hffffffff);
		apb(1'b0, A_SEL, 32'h0);
		chk("sel_field", rd, 32'h7);
		apb(1'b1, A_SEL, 32'h0);
		wait_rst(300);
		chk("idle_off", 32'(rst_out), 32'h0);
	endtask
	task automatic t_broken;
		key(hwdt_pkg::KEY_FIRST);
		apb(1'b1, A_SEL, 32'h0);
		key(hwdt_pkg::KEY_SECOND);
		wait_rst(300);
		chk("broken_key", 32'(rst_out), 32'h0);
	endtask
	task automatic t_ovf(input logic [2:0] s);
		apb(1'b1, A_SEL, 32'(s));
		arm();
		expect_ovf(2 ** (BB + 32'(s)) - 1);
		wait_rst(450);
		chk("off_after_ovf", 32'(rst_out), 32'h0);
	endtask
	task automatic t_service;
		apb(1'b1, A_SEL, 32'h0);
		arm();
		repeat (3) begin
			wait_rst(150);
			chk("in_time", 32'(rst_out), 32'h0);
			key(hwdt_pkg::KEY_FIRST);
			key(hwdt_pkg::KEY_FIRST);
			key(hwdt_pkg::KEY_SECOND);
		end
		chk("serviced", 32'(rst_out), 32'h0);
		expect_ovf(T0);
	endtask
	task automatic t_hold;
		arm();
		osc_running <= 1'b0;
		wait_rst(400);
		chk("osc_hold", 32'(rst_out), 32'h0);
		osc_running <= 1'b1;
		pd_exit_by_int <= 1'b1;
		wake_int_n <= 1'b0;
		wait_rst(400);
		chk("wake_hold", 32'(rst_out), 32'h0);
		wake_int_n <= 1'b1;
		pd_exit_by_int <= 1'b0;
		wait_rst(T0 * 12 + 40);
		chk("resume_ovf", 32'(c <= T0 * 12 + 3), 32'h1);
		repeat (120) @(posedge pclk);
		apb(1'b1, A_SEL, 32'h5);
		arm();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, A_SEL, 32'h0);
		chk("sel_rereset", rd, 32'h0);
		wait_rst(400);
		chk("reset_off", 32'(rst_out), 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		{pclk, presetn, psel, penable, pwrite, pd_exit_by_int} = 6'h0;
		{osc_running, wake_int_n} = 2'h3;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_broken();
		t_ovf(3'h0);
		t_ovf(3'h1);
		t_service();
		t_hold();
		end_of_test();
	end
	initial begin
		#400000;
		n_errors++;
		end_of_test();
	end
endmodule // hardware_watchdog_timer_tb
